// ### logic/fcp_core.sv
// Flash configuration and protection registers behind an AXI4-Lite slave.
// Assumes the command controller supplies the status flags and the security
// byte on the same clock; array accesses arrive as single-cycle strobes.
//
// Operation
// RULE1 - Config: three writable bits, rest zero
// RULE2 - Key gate writable only when key enabled
// RULE3 - Key enable value 10 only enables
// RULE4 - Buffer-empty enable gates empty interrupt
// RULE5 - Complete enable gates complete interrupt
// RULE6 - Gate clear: writes start commands
// RULE7 - Gate set: writes are keys, reads invalid
// RULE8 - Protection register always readable
// RULE9 - Polarity bit only clears
// RULE10 - Low size writable while low disabled
// RULE11 - High size writable while high disabled
// RULE12 - Protection loaded from 0xFF0D at reset
// RULE13 - Software unprotects top before reprogramming byte
// RULE14 - Protected program or erase flags violation
// RULE15 - Mass erase needs all protection off
// RULE16 - Polarity one: cleared disable protects range
// RULE17 - Polarity zero: cleared disable unprotects range
// RULE18 - Disable bits deactivate their ranges
// RULE19 - Software leaves reserved bit erased
// RULE20 - High range sizes end at 0xFFFF
// RULE21 - Low range sizes start at 0x4000
// RULE22 - Only protection-adding writes accepted
// RULE23 - Interrupt is OR of gated flags
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
module fcp_core
	import fcp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] security_register,
	input wire logic buffer_empty_flag,
	input wire logic command_complete_flag,
	input wire logic array_wr,
	input wire logic array_rd,
	output logic flash_irq,
	output logic cmd_start,
	output logic key_word_wr,
	output logic array_rd_invalid,
	output logic array_alter
);
	typedef struct packed {
		logic awready;
		logic wready;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [7:0] cfg;
		logic [7:0] prot;
		logic viol;
		fcp_ld_t ld;
		logic irq;
		logic cmd_start;
		logic key_wr;
		logic rd_inv;
		logic alter;
	} fcp_state_t;

	fcp_state_t st_ff;
	fcp_state_t nxt_st;
	logic [7:0] nv_rd;
	logic nv_wr;
	logic [7:0] nv_wdata;

	// High range start for a size code
	function automatic logic [15:0] hi_start(input logic [1:0] sz);
		// RULE20 high range table
		case (sz)
			2'h0: hi_start = 16'hF800;
			2'h1: hi_start = 16'hF000;
			2'h2: hi_start = 16'hE000;
			default: hi_start = 16'hC000;
		endcase
	endfunction

	// Low range end for a size code
	function automatic logic [15:0] lo_end(input logic [1:0] sz);
		// RULE21 low range table
		case (sz)
			2'h0: lo_end = 16'h41FF;
			2'h1: lo_end = 16'h43FF;
			2'h2: lo_end = 16'h47FF;
			default: lo_end = 16'h4FFF;
		endcase
	endfunction

	// Whether an address is protected under a protection byte
	function automatic logic is_prot(input logic [7:0] p,
		input logic [15:0] a);
		logic in_hi;
		logic in_lo;
		logic hi_on;
		logic lo_on;
		in_hi = (a >= hi_start(p[FCP_PR_HS_LO+:2])) && (a <= FCP_HIGH_TOP);
		in_lo = (a >= FCP_LOW_BASE) && (a <= lo_end(p[FCP_PR_LS_LO+:2]));
		// RULE18 disable bits
		hi_on = !p[FCP_PR_HDIS] && in_hi;
		lo_on = !p[FCP_PR_LDIS] && in_lo;
		// RULE16 RULE17 polarity swap
		if (p[FCP_PR_OPEN]) begin
			is_prot = hi_on || lo_on;
		end else begin
			is_prot = !(hi_on || lo_on);
		end
	endfunction

	// Merge a protection write; polarity only clears and enabled sizes keep their value
	function automatic logic [7:0] prot_merge(input logic [7:0] cur,
		input logic [7:0] wr);
		logic [7:0] n;
		n = cur;
		// RULE9 polarity only clears
		n[FCP_PR_OPEN] = cur[FCP_PR_OPEN] & wr[FCP_PR_OPEN];
		n[FCP_PR_NV6] = wr[FCP_PR_NV6];
		n[FCP_PR_HDIS] = wr[FCP_PR_HDIS];
		n[FCP_PR_LDIS] = wr[FCP_PR_LDIS];
		// RULE11 high size frozen once enabled
		if (cur[FCP_PR_HDIS]) begin
			n[FCP_PR_HS_LO+:2] = wr[FCP_PR_HS_LO+:2];
		end
		// RULE10 low size frozen once enabled
		if (cur[FCP_PR_LDIS]) begin
			n[FCP_PR_LS_LO+:2] = wr[FCP_PR_LS_LO+:2];
		end
		prot_merge = n;
	endfunction

	// Coverage test over range endpoints; a valid move never unprotects
	function automatic logic adds_only(input logic [7:0] cur,
		input logic [7:0] n);
		logic ok;
		logic [15:0] pts [10];
		pts[0] = 16'h4000;
		pts[1] = 16'h41FF;
		pts[2] = 16'h43FF;
		pts[3] = 16'h47FF;
		pts[4] = 16'h4FFF;
		pts[5] = 16'hC000;
		pts[6] = 16'hE000;
		pts[7] = 16'hF000;
		pts[8] = 16'hF800;
		pts[9] = 16'h8000;
		ok = 1'b1;
		for (int i = 0; i < 10; i++) begin
			if (is_prot(cur, pts[i]) && !is_prot(n, pts[i])) begin
				ok = 1'b0;
			end
		end
		// Polarity zero with both ranges open is a dead end scenario
		if (!n[FCP_PR_OPEN] && cur[FCP_PR_OPEN] &&
			!(n[FCP_PR_HDIS] && n[FCP_PR_LDIS]) &&
			!(!n[FCP_PR_HDIS] || !n[FCP_PR_LDIS])) begin
			ok = 1'b0;
		end
		adds_only = ok;
	endfunction

	// Nonvolatile protection byte holder; index 1 is the byte at 0xFF0D
	fcp_nvbyte u_nv (
		.mclk(mclk),
		.rst_b(rst_b),
		.wr_en(nv_wr),
		.wr_idx(2'h1),
		.wr_data(nv_wdata),
		.rd_idx(2'h1),
		.rd_data(nv_rd)
	);

	// Next state for bus slave, registers and array strobes
	always_comb begin
		logic do_wr;
		logic [7:0] wb;
		logic [7:0] cand;
		logic [15:0] caddr;
		logic [1:0] cop;
		logic viol_set;
		logic key_en;
		do_wr = 1'b0;
		wb = 8'h00;
		cand = 8'h00;
		caddr = 16'h0000;
		cop = 2'h0;
		viol_set = 1'b0;
		nv_wr = 1'b0;
		nv_wdata = 8'h00;
		nxt_st = st_ff;
		// RULE3 only encoding 10 enables
		key_en = security_register[FCP_SEC_KEY_LO+:2] == FCP_KEY_ENABLED;

		// RULE12 reset load of the protection byte
		case (st_ff.ld)
			FCP_LD_IDLE: begin
				nxt_st.ld = FCP_LD_WAIT;
			end
			FCP_LD_WAIT: begin
				nxt_st.prot = nv_rd;
				nxt_st.ld = FCP_LD_DONE;
			end
			default: begin
				nxt_st.ld = FCP_LD_DONE;
			end
		endcase

		// Write address and data are taken in either order
		if (s_axi_awvalid && st_ff.awready) begin
			nxt_st.awaddr = s_axi_awaddr;
			nxt_st.awready = 1'b0;
		end
		if (s_axi_wvalid && st_ff.wready) begin
			nxt_st.wdata = s_axi_wdata;
			nxt_st.wstrb = s_axi_wstrb;
			nxt_st.wready = 1'b0;
		end
		do_wr = !st_ff.awready && !st_ff.wready && !st_ff.bvalid &&
			st_ff.ld == FCP_LD_DONE;
		wb = st_ff.wstrb[0] ? st_ff.wdata[7:0] : 8'h00;
		if (do_wr) begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = FCP_RESP_OKAY;
			if (st_ff.awaddr == FCP_OFS_CONFIG) begin
				if (st_ff.wstrb[0]) begin
					// RULE1 writable bits only
					nxt_st.cfg[FCP_CFG_BEIE] = wb[FCP_CFG_BEIE];
					nxt_st.cfg[FCP_CFG_COMPLETE_IRQ_ENABLE] = wb[FCP_CFG_COMPLETE_IRQ_ENABLE];
					// RULE2 key gate needs key enable
					if (key_en) begin
						nxt_st.cfg[FCP_CFG_KEY] = wb[FCP_CFG_KEY];
					end
				end
			end else if (st_ff.awaddr == FCP_OFS_PROT) begin
				if (st_ff.wstrb[0]) begin
					cand = prot_merge(st_ff.prot, wb);
					// RULE22 reject protection loss
					if (adds_only(st_ff.prot, cand)) begin
						nxt_st.prot = cand;
					end
				end
			end else if (st_ff.awaddr == FCP_OFS_STATUS) begin
				// Violation flag clears by writing one
				if (st_ff.wstrb[0] && wb[FCP_ST_VIOL]) begin
					nxt_st.viol = 1'b0;
				end
			end else if (st_ff.awaddr == FCP_OFS_CMD) begin
				caddr = st_ff.wdata[FCP_CMD_ADDR_LO+:16];
				cop = st_ff.wdata[FCP_CMD_OP_LO+:2];
				if (cop == FCP_OP_MASS) begin
					// RULE15 mass erase only fully open
					if (st_ff.prot[FCP_PR_OPEN] && st_ff.prot[FCP_PR_HDIS] &&
						st_ff.prot[FCP_PR_LDIS]) begin
						nxt_st.alter = 1'b1;
					end else begin
						viol_set = 1'b1;
					end
				end else if (cop == FCP_OP_PROG || cop == FCP_OP_ERASE) begin
					// RULE14 protected target refused
					if (is_prot(st_ff.prot, caddr)) begin
						viol_set = 1'b1;
					end else begin
						nxt_st.alter = 1'b1;
						// RULE13 new protection byte for next reset
						if (cop == FCP_OP_PROG && caddr == FCP_NV_PROT_ADDR) begin
							nv_wr = 1'b1;
							nv_wdata = st_ff.wdata[31:24];
						end
					end
				end
			end else if (st_ff.awaddr == FCP_OFS_LOAD) begin
				nxt_st.bresp = FCP_RESP_OKAY;
			end else begin
				nxt_st.bresp = FCP_RESP_SLVERR;
			end
		end
		if (st_ff.bvalid && s_axi_bready) begin
			nxt_st.bvalid = 1'b0;
			nxt_st.awready = 1'b1;
			nxt_st.wready = 1'b1;
		end
		// Set wins over the software clear
		if (viol_set) begin
			nxt_st.viol = 1'b1;
		end

		// Read channel; one read at a time
		if (s_axi_arvalid && st_ff.arready) begin
			nxt_st.arready = 1'b0;
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = FCP_RESP_OKAY;
			nxt_st.rdata = 32'h0000_0000;
			if (s_axi_araddr == FCP_OFS_CONFIG) begin
				nxt_st.rdata[7:0] = st_ff.cfg;
			end else if (s_axi_araddr == FCP_OFS_PROT) begin
				// RULE8 readable in every mode
				nxt_st.rdata[7:0] = st_ff.prot;
			end else if (s_axi_araddr == FCP_OFS_STATUS) begin
				nxt_st.rdata[FCP_ST_VIOL] = st_ff.viol;
				nxt_st.rdata[FCP_ST_BE] = buffer_empty_flag;
				nxt_st.rdata[FCP_ST_CC] = command_complete_flag;
			end else if (s_axi_araddr == FCP_OFS_CMD) begin
				nxt_st.rdata = 32'h0000_0000;
			end else begin
				nxt_st.rresp = FCP_RESP_SLVERR;
			end
		end
		if (st_ff.rvalid && s_axi_rready) begin
			nxt_st.rvalid = 1'b0;
			nxt_st.arready = 1'b1;
		end

		// RULE6 gate clear starts command sequence
		nxt_st.cmd_start = array_wr && !st_ff.cfg[FCP_CFG_KEY];
		// RULE7 gate set takes key words
		nxt_st.key_wr = array_wr && st_ff.cfg[FCP_CFG_KEY];
		nxt_st.rd_inv = array_rd && st_ff.cfg[FCP_CFG_KEY];
		if (!do_wr || st_ff.awaddr != FCP_OFS_CMD) begin
			nxt_st.alter = 1'b0;
		end

		// RULE4 RULE5 RULE23 gated interrupt request
		nxt_st.irq = (st_ff.cfg[FCP_CFG_BEIE] && buffer_empty_flag) ||
			(st_ff.cfg[FCP_CFG_COMPLETE_IRQ_ENABLE] && command_complete_flag);
	end

	// All state in one register; bus channels idle ready after reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			st_ff <= '0;
			st_ff.awready <= 1'b1;
			st_ff.wready <= 1'b1;
			st_ff.arready <= 1'b1;
			st_ff.cfg <= FCP_CFG_RST;
			st_ff.prot <= FCP_PR_RST;
			st_ff.ld <= FCP_LD_IDLE;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign s_axi_awready = st_ff.awready;
	assign s_axi_wready = st_ff.wready;
	assign s_axi_bvalid = st_ff.bvalid;
	assign s_axi_bresp = st_ff.bresp;
	assign s_axi_arready = st_ff.arready;
	assign s_axi_rvalid = st_ff.rvalid;
	assign s_axi_rdata = st_ff.rdata;
	assign s_axi_rresp = st_ff.rresp;
	assign flash_irq = st_ff.irq;
	assign cmd_start = st_ff.cmd_start;
	assign key_word_wr = st_ff.key_wr;
	assign array_rd_invalid = st_ff.rd_inv;
	assign array_alter = st_ff.alter;
endmodule

// ### logic/fcp_pkg.sv
// Constants and types for the flash configuration and protection block.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit flash address space.
package fcp_pkg;

	// Register byte offsets
	localparam logic [7:0] FCP_OFS_SECURITY = 8'h01;
	localparam logic [7:0] FCP_OFS_CONFIG = 8'h00;
	localparam logic [7:0] FCP_OFS_PROT = 8'h04;
	localparam logic [7:0] FCP_OFS_STATUS = 8'h08;
	localparam logic [7:0] FCP_OFS_CMD = 8'h0C;
	localparam logic [7:0] FCP_OFS_LOAD = 8'h10;

	// Configuration register fields
	localparam int FCP_CFG_BEIE = 7;
	localparam int FCP_CFG_COMPLETE_IRQ_ENABLE = 6;
	localparam int FCP_CFG_KEY = 5;
	localparam logic [7:0] FCP_CFG_RST = 8'h00;

	// Protection register fields
	localparam int FCP_PR_OPEN = 7;
	localparam int FCP_PR_NV6 = 6;
	localparam int FCP_PR_HDIS = 5;
	localparam int FCP_PR_HS_LO = 3;
	localparam int FCP_PR_LDIS = 2;
	localparam int FCP_PR_LS_LO = 0;
	localparam logic [7:0] FCP_PR_RST = 8'hFF;

	// Backdoor key enable field: only this encoding enables
	localparam logic [1:0] FCP_KEY_ENABLED = 2'h2;
	localparam int FCP_SEC_KEY_LO = 6;

	// Nonvolatile protection byte address
	localparam logic [15:0] FCP_NV_PROT_ADDR = 16'hFF0D;

	// Range bounds
	localparam logic [15:0] FCP_LOW_BASE = 16'h4000;
	localparam logic [15:0] FCP_HIGH_TOP = 16'hFFFF;

	// Command register fields
	localparam int FCP_CMD_ADDR_LO = 0;
	localparam int FCP_CMD_OP_LO = 16;
	localparam logic [1:0] FCP_OP_PROG = 2'h1;
	localparam logic [1:0] FCP_OP_ERASE = 2'h2;
	localparam logic [1:0] FCP_OP_MASS = 2'h3;

	// Status register fields
	localparam int FCP_ST_VIOL = 0;
	localparam int FCP_ST_BE = 1;
	localparam int FCP_ST_CC = 2;

	// AXI responses
	localparam logic [1:0] FCP_RESP_OKAY = 2'h0;
	localparam logic [1:0] FCP_RESP_SLVERR = 2'h2;

	typedef enum logic [1:0] {
		FCP_LD_IDLE,
		FCP_LD_WAIT,
		FCP_LD_DONE
	} fcp_ld_t;

endpackage

// ### logic/fcp_nvbyte.sv
// Small holding store for the nonvolatile configuration bytes.
// Assumes the loader reads one byte at a time; read data are registered.
`timescale 1ns/1ps
module fcp_nvbyte
	import fcp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [7:0] wr_data,
	input wire logic [1:0] rd_idx,
	output logic [7:0] rd_data
);
	// Erased flash reads as all ones until first programmed
	logic [7:0] mem_ff [4] = '{default: 8'hFF};

	// Cells keep their contents through reset, or the protection
	// byte programmed for the next reset would be lost by that reset
	always_ff @(posedge mclk) begin
		if (wr_en) begin
			mem_ff[wr_idx] <= wr_data;
		end
	end

	// Registered read port; only the output register is reset
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data <= 8'hFF;
		end else begin
			rd_data <= mem_ff[rd_idx];
		end
	end
endmodule

// ### test/fcp_ctl_model.sv
// Behavioural model of the flash command controller beside the block.
// Assumes cmd_start is a one-cycle pulse on mclk; key_en sets the key field.
`timescale 1ns/1ps
module fcp_ctl_model
	import fcp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic cmd_start,
	input wire logic [1:0] key_en,
	output logic [7:0] security_register,
	output logic buffer_empty_flag,
	output logic command_complete_flag
);
	logic [2:0] busy_ff;
	// A started command holds both flags low for four cycles
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			busy_ff <= 3'h0;
		end else if (cmd_start) begin
			busy_ff <= 3'h4;
		end else if (busy_ff != 3'h0) begin
			busy_ff <= busy_ff - 3'h1;
		end
	end
	// Idle controller shows empty buffer and completed commands
	assign buffer_empty_flag = (busy_ff == 3'h0);
	assign command_complete_flag = (busy_ff == 3'h0);
	assign security_register = {key_en, 6'h00};
endmodule

// ### test/fcp_core_monitor.sv
// Concurrent checks on the ports of the configuration and protection block.
// Assumes it is bound into fcp_core; one clock domain, async low reset.
`timescale 1ns/1ps
module fcp_core_monitor
	import fcp_pkg::*;
(
	input wire logic mclk,
	input wire logic rst_b,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic buffer_empty_flag,
	input wire logic command_complete_flag,
	input wire logic array_wr,
	input wire logic array_rd,
	input wire logic flash_irq,
	input wire logic cmd_start,
	input wire logic key_word_wr,
	input wire logic array_rd_invalid,
	input wire logic array_alter
);
	// All checks share the bus clock; reset mutes them
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_b);
	property p_irq_off;
		!buffer_empty_flag && !command_complete_flag |=> !flash_irq;
	endproperty
	a_irq_off: assert property (p_irq_off)
		else $error("irq without flag");
	property p_wr_out;
		array_wr |=> (cmd_start ^ key_word_wr);
	endproperty
	a_wr_out: assert property (p_wr_out)
		else $error("array write lost");
	property p_no_wr;
		!array_wr |=> !cmd_start && !key_word_wr;
	endproperty
	a_no_wr: assert property (p_no_wr)
		else $error("stray write pulse");
	property p_rd_idle;
		!array_rd |=> !array_rd_invalid;
	endproperty
	a_rd_idle: assert property (p_rd_idle)
		else $error("stray read pulse");
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_b_hold: assert property (p_b_hold)
		else $error("write answer lost");
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	a_r_hold: assert property (p_r_hold)
		else $error("read answer lost");
	property p_r_ans;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_r_ans: assert property (p_r_ans)
		else $error("read not answered");
	property p_r_zero;
		s_axi_rvalid && s_axi_rresp == FCP_RESP_OKAY |->
			s_axi_rdata[31:8] == 24'h0;
	endproperty
	a_r_zero: assert property (p_r_zero)
		else $error("upper bits set");
	// Array change only ever shows beside the command write answer
	property p_alter_ans;
		array_alter |-> s_axi_bvalid;
	endproperty
	a_alter_ans: assert property (p_alter_ans)
		else $error("alter without answer");
endmodule

bind fcp_core fcp_core_monitor i_mon (.*);

// ### test/testbench.sv
// Self-checking bench for the flash configuration and protection block.
// Assumes fcp_core and the controller model share one clock and reset.
`timescale 1ns/1ps
module testbench
	import fcp_pkg::*;
;
	logic mclk = 1'h0;
	logic rst_b = 1'h0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hF;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
	logic array_wr = 1'h0, array_rd = 1'h0;
	logic [1:0] key_en = 2'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, alt;
	logic s_axi_rvalid, flash_irq, cmd_start, key_word_wr, array_alter;
	logic array_rd_invalid, buffer_empty_flag, command_complete_flag;
	logic [1:0] s_axi_bresp, s_axi_rresp, rd_resp, wr_resp;
	logic [31:0] s_axi_rdata, rd_val;
	logic [7:0] security_register;
	int error_cnt = 0, checked = 0;
	// 40 MHz bus clock
	always #12.5 mclk = ~mclk;
	fcp_core i_dut (.*);
	fcp_ctl_model i_ctl (.*);
	task conclude;
		$display("checked %0d, wrong %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask
	task give_up;
		error_cnt++;
		$display("wrong value at %0t: no answer", $time);
		conclude();
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: saw %h not %h", $time, seen, exp);
		end
	endtask
	// Write; address and data are released as each is taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (s_axi_awready) s_axi_awvalid <= 1'h0;
			if (s_axi_wready) s_axi_wvalid <= 1'h0;
			// Answer taken at the edge that sees bvalid and bready high
			if (s_axi_bvalid && s_axi_bready) begin
				wr_resp = s_axi_bresp;
				s_axi_bready <= 1'h0;
				return;
			end
			// Ready comes late so the slave must hold its answer;
			// the alter pulse stands only in the first answer cycle
			if (s_axi_bvalid) begin
				alt = array_alter;
				s_axi_bready <= 1'h1;
			end
		end
		give_up();
	endtask
	task rd(input logic [7:0] a);
		@(posedge mclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'h1;
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk);
			if (s_axi_arready) s_axi_arvalid <= 1'h0;
			if (s_axi_rvalid && s_axi_rready) begin
				rd_val = s_axi_rdata;
				rd_resp = s_axi_rresp;
				s_axi_rready <= 1'h0;
				return;
			end
			// Late ready makes the slave hold its read data a cycle
			if (s_axi_rvalid) s_axi_rready <= 1'h1;
		end
		give_up();
	endtask
	task do_reset;
		rst_b <= 1'h0;
		repeat (10) @(posedge mclk);
		rst_b <= 1'h1;
		repeat (4) @(posedge mclk);
	endtask
	// One-cycle array strobe; outputs settle one cycle later
	task strobe(input logic w);
		@(posedge mclk);
		array_wr <= w;
		array_rd <= !w;
		@(posedge mclk);
		array_wr <= 1'h0;
		array_rd <= 1'h0;
		#1;
	endtask
	task t_reset;
		rd(FCP_OFS_CONFIG);
		chk(rd_val, {24'h0, FCP_CFG_RST});
		rd(FCP_OFS_PROT);
		chk(rd_val, {24'h0, FCP_PR_RST});
		rd(8'h40);
		chk(rd_resp, FCP_RESP_SLVERR);
		wr(8'h40, 32'h0);
		chk(wr_resp, FCP_RESP_SLVERR);
		$display("test reset done");
	endtask
	task t_key;
		logic [1:0] ks [4];
		ks = '{2'h0, 2'h1, 2'h3, 2'h2};
		wr(FCP_OFS_CONFIG, 32'hFFFFFFFF);
		rd(FCP_OFS_CONFIG);
		chk(rd_val, 32'hC0);
		wr(FCP_OFS_CONFIG, 32'h0);
		for (int k = 0; k < 4; k++) begin
			key_en <= ks[k];
			wr(FCP_OFS_CONFIG, 32'h20);
			rd(FCP_OFS_CONFIG);
			chk(rd_val, (ks[k] == FCP_KEY_ENABLED) ? 32'h20 : 32'h0);
		end
		strobe(1'h1);
		chk({cmd_start, key_word_wr}, 2'h1);
		strobe(1'h0);
		chk(array_rd_invalid, 1'h1);
		wr(FCP_OFS_CONFIG, 32'h0);
		strobe(1'h1);
		chk({cmd_start, key_word_wr}, 2'h2);
		strobe(1'h0);
		chk(array_rd_invalid, 1'h0);
		key_en <= 2'h0;
		$display("test key gate done");
	endtask
	task t_irq;
		wr(FCP_OFS_CONFIG, 32'h80);
		repeat (2) @(posedge mclk);
		chk(flash_irq, 1'h1);
		wr(FCP_OFS_CONFIG, 32'h40);
		repeat (2) @(posedge mclk);
		chk(flash_irq, 1'h1);
		wr(FCP_OFS_CONFIG, 32'h0);
		repeat (2) @(posedge mclk);
		chk(flash_irq, 1'h0);
		wr(FCP_OFS_CONFIG, 32'hC0);
		strobe(1'h1);
		repeat (2) @(posedge mclk);
		#1;
		chk(flash_irq, 1'h0);
		repeat (8) @(posedge mclk);
		chk(flash_irq, 1'h1);
		wr(FCP_OFS_CONFIG, 32'h0);
		$display("test interrupts done");
	endtask
	task t_prot;
		logic [17:0] cmds [5];
		cmds = '{18'h1C000, 18'h1BFFF, 18'h14FFF, 18'h15000, 18'h30000};
		// top still open, store byte; bit 6 kept
		wr(FCP_OFS_CMD, {8'hDB, 8'h01, FCP_NV_PROT_ADDR});
		chk(alt, 1'h1);
		chk(wr_resp, FCP_RESP_OKAY);
		// Fully open protection lets a mass erase through
		wr(FCP_OFS_CMD, 32'h30000);
		chk(alt, 1'h1);
		wr(FCP_OFS_PROT, 32'h7F);
		wr(FCP_OFS_PROT, 32'h64);
		rd(FCP_OFS_PROT);
		chk(rd_val, 32'h64);
		wr(FCP_OFS_PROT, 32'hFF);
		rd(FCP_OFS_PROT);
		// Polarity stays clear; sizes follow while disables are set
		chk(rd_val, 32'h7F);
		wr(FCP_OFS_CMD, 32'h18000);
		chk(alt, 1'h0);
		rd(FCP_OFS_STATUS);
		chk(rd_val, 32'h07);
		wr(FCP_OFS_STATUS, 32'h01);
		rd(FCP_OFS_STATUS);
		chk(rd_val, 32'h06);
		do_reset();
		rd(FCP_OFS_PROT);
		chk(rd_val, 32'hDB);
		for (int i = 0; i < 5; i++) begin
			wr(FCP_OFS_CMD, {14'h0, cmds[i]});
			chk(alt, i == 1 || i == 3);
		end
		wr(FCP_OFS_PROT, 32'hFF);
		rd(FCP_OFS_PROT);
		chk(rd_val, 32'hDB);
		$display("test protection done");
	endtask
	// Cut a hang short
	initial begin
		#2000000;
		give_up();
	end
	initial begin
		do_reset();
		t_reset();
		t_key();
		t_irq();
		t_prot();
		conclude();
	end
endmodule
